// *** src/oc_channel.sv ***
// one compare output channel: prepared level and pin
`timescale 1ns/1ps
module oc_channel #(
  parameter int CW = timer_evt_pkg::CNT_W
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  ce,
  input  wire logic [CW-1:0]         cnt,
  input  wire logic                  cnt_down,
  input  wire logic [CW-1:0]         cmp_val,
  input  wire timer_evt_pkg::chan_cfg_s cfg,
  input  wire logic                  etr_filt,
  input  wire logic                  trig_edge,
  input  wire logic                  chan_en,
  input  wire logic                  chan_pol,
  output logic                       match_evt,
  output logic                       pre_q,
  output logic                       pin_q
);
  import timer_evt_pkg::*;

  logic match;
  logic match_q;
  logic pwm_act;
  logic pwm_mode;
  logic pre_d;

  assign match = (cnt == cmp_val);
  assign match_evt = match && !match_q;
  assign pwm_act = cnt_down ? (cnt <= cmp_val) : (cnt < cmp_val);
  assign pwm_mode = (cfg.oc_mode == OC_PWM0) || (cfg.oc_mode == OC_PWM1);

  always_comb begin
    pre_d = pre_q;
    case (cfg.oc_mode)
      OC_FROZEN: pre_d = pre_q;
      OC_SET:    pre_d = match_evt ? 1'b1 : pre_q;
      OC_CLR:    pre_d = match_evt ? 1'b0 : pre_q;
      OC_TOGGLE: pre_d = match_evt ? !pre_q : pre_q;
      OC_LOW:    pre_d = 1'b0;
      OC_HIGH:   pre_d = 1'b1;
      OC_PWM0:   pre_d = (cfg.fast_en && trig_edge) ? 1'b0 : pwm_act;
      OC_PWM1:   pre_d = (cfg.fast_en && trig_edge) ? 1'b1 : !pwm_act;
      default:   pre_d = pre_q;
    endcase
    if (cfg.clr_en && etr_filt) begin
      pre_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      // no match event straight out of reset
      match_q <= 1'b1;
      pre_q   <= 1'b0;
    end else if (ce) begin
      match_q <= match;
      pre_q   <= pre_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_q <= 1'b0;
    end else if (ce) begin
      pin_q <= (chan_en && cfg.ms == MS_OUTPUT) ? (pre_q ^ chan_pol) : 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);

  chk_force_low: assert property (
    cfg.oc_mode == OC_LOW |=> !pre_q)
    else $error("force low not low");
  chk_clear_low: assert property (
    cfg.clr_en && etr_filt |=> !pre_q)
    else $error("clear enable did not clear");
  chk_fast_level: assert property (
    cfg.fast_en && pwm_mode && trig_edge && cfg.ms == MS_OUTPUT &&
    !(cfg.clr_en && etr_filt)
    |=> pre_q == (cfg.oc_mode == OC_PWM1) ##[1:2]
        pin_q == ($past(pre_q, 1) ^ chan_pol) || !chan_en)
    else $error("fast trigger path too slow");
  chk_pin_pol: assert property (
    chan_en && cfg.ms == MS_OUTPUT |=> pin_q == ($past(pre_q) ^ $past(chan_pol)))
    else $error("pin polarity wrong");
endmodule

// *** src/timer_event_gen_and_compare_ctl.sv ***
// timer event generation, flags and compare control for two channels
//
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps
module timer_event_gen_and_compare_ctl #(
  parameter int CW = timer_evt_pkg::CNT_W
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic [31:0]               hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [CW-1:0]        cnt_val,
  input  wire logic                 cnt_down,
  input  wire logic [CW-1:0]        autoreload,
  input  wire logic                 update_event_in,
  input  wire logic                 trig_edge,
  input  wire logic                 trig_src_internal,
  input  wire logic                 ext_trigger_filtered,
  input  wire logic [1:0]           own_filtered_input,
  input  wire logic [1:0]           neighbor_filtered_input,
  input  wire logic                 internal_trigger_sel,
  output logic                      cnt_load_stb,
  output logic [CW-1:0]             cnt_load_val,
  output logic                      psc_clear,
  output logic [1:0]                chan_output_pin,
  output logic                      int_req,
  output logic                      dma_req
);
  import timer_evt_pkg::*;

  if (CW < 2 || CW > 32) begin : g_bad_width
    $error("counter width must be 2 to 32");
  end

  ahb_ap_s            ap_q;
  logic               rd_wait_q;
  logic [31:0]        hrdata_q;
  logic [31:0]        rd_word;
  logic [31:0]        status_word;
  logic               wr;
  logic               rd_fire;
  logic [5:0]         ofs;
  logic [IEN_W-1:0]   ien_q;
  logic [GEN_W-1:0]   gen_q;
  logic [15:0]        ctl_q;
  chan_cfg_s          cfg [NCH];
  logic [NCH-1:0]     en_q;
  logic [NCH-1:0]     pol_q;
  logic [CW-1:0]      cv_sh_q [NCH];
  logic [CW-1:0]      cv_act_q [NCH];
  logic               upd_flag_q;
  logic               trg_flag_q;
  logic [NCH-1:0]     cc_flag_q;
  logic [NCH-1:0]     ovc_flag_q;
  logic [NCH-1:0]     sel_in;
  logic [NCH-1:0]     sel_q;
  logic [NCH-1:0]     cap;
  logic [NCH-1:0]     inmode;
  logic [NCH-1:0]     match_evt;
  logic [NCH-1:0]     pre;
  logic [NCH-1:0]     cc_set;
  logic [NCH-1:0]     cc_clr;
  logic [NCH-1:0]     wr_cv;
  logic               upd_evt;
  logic               trg_set;
  logic [IEN_W-1:0]   pend;

  // ahb-lite slave: zero-wait writes, one wait state on reads
  assign hreadyout = ce && !rd_wait_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wr = ap_q.valid && ap_q.write && ce && !rd_wait_q;
  assign rd_fire = rd_wait_q && ce;
  assign ofs = ap_q.word;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ap_q <= '0;
    end else if (ce && hready) begin
      ap_q.valid <= hsel && htrans[HTRANS_ACT];
      ap_q.write <= hwrite;
      ap_q.word  <= haddr[7:2];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_wait_q <= 1'b0;
    end else if (ce) begin
      rd_wait_q <= hready && hsel && htrans[HTRANS_ACT] && !hwrite;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata_q <= RST_WORD;
    end else if (rd_fire) begin
      hrdata_q <= rd_word;
    end
  end

  always_comb begin
    status_word = RST_WORD;
    status_word[BIT_UPD] = upd_flag_q;
    status_word[BIT_TRG] = trg_flag_q;
    status_word[BIT_CH0 +: NCH] = cc_flag_q;
    status_word[BIT_OVC0 +: NCH] = ovc_flag_q;
  end

  always_comb begin
    rd_word = RST_WORD;
    case (ofs)
      OFS_INT_EN[7:2]: rd_word[IEN_W-1:0] = ien_q;
      OFS_STATUS[7:2]: rd_word = status_word;
      OFS_CHCTL[7:2]:  rd_word[15:0] = ctl_q;
      OFS_CHEN[7:2]: begin
        rd_word[0] = en_q[0];
        rd_word[BIT_POL] = pol_q[0];
        rd_word[CHEN_STRIDE] = en_q[1];
        rd_word[CHEN_STRIDE + BIT_POL] = pol_q[1];
      end
      OFS_CV0[7:2]:    rd_word = 32'(cv_sh_q[0]);
      OFS_CV1[7:2]:    rd_word = 32'(cv_sh_q[1]);
      // event register and holes read zero
      default:         rd_word = RST_WORD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gen_q <= '0;
    end else if (ce) begin
      gen_q <= (wr && ofs == OFS_SWEVT[7:2]) ? hwdata[GEN_W-1:0] : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ien_q <= '0;
    end else if (wr && ofs == OFS_INT_EN[7:2]) begin
      ien_q <= hwdata[IEN_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      en_q  <= '0;
      pol_q <= '0;
    end else if (wr && ofs == OFS_CHEN[7:2]) begin
      en_q[0]  <= hwdata[0];
      pol_q[0] <= hwdata[BIT_POL];
      en_q[1]  <= hwdata[CHEN_STRIDE];
      pol_q[1] <= hwdata[CHEN_STRIDE + BIT_POL];
    end
  end

  // channel fields, mode select locked while enabled
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_q <= '0;
    end else if (wr && ofs == OFS_CHCTL[7:2]) begin
      for (int i = 0; i < NCH; i++) begin
        ctl_q[i*CFG_W+2 +: CFG_W-2] <= hwdata[i*CFG_W+2 +: CFG_W-2];
        if (!en_q[i]) begin
          ctl_q[i*CFG_W +: 2] <= hwdata[i*CFG_W +: 2];
        end
      end
    end
  end

  assign upd_evt = update_event_in || gen_q[BIT_UPD];
  assign trg_set = trig_edge || gen_q[BIT_TRG];

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign cfg[i] = chan_cfg_s'(ctl_q[i*CFG_W +: CFG_W]);
    assign inmode[i] = cfg[i].ms != MS_OUTPUT;
    assign wr_cv[i] = wr && ofs == (i == 0 ? OFS_CV0[7:2] : OFS_CV1[7:2]);

    always_comb begin
      case (cfg[i].ms)
        MS_OWN:   sel_in[i] = own_filtered_input[i];
        MS_NEIGH: sel_in[i] = neighbor_filtered_input[i];
        MS_ITS:   sel_in[i] = internal_trigger_sel && trig_src_internal;
        default:  sel_in[i] = 1'b0;
      endcase
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        sel_q[i] <= 1'b0;
      end else if (ce) begin
        sel_q[i] <= sel_in[i];
      end
    end

    // capture on software event or input edge
    assign cap[i] = inmode[i] && (gen_q[BIT_CH0+i] ||
                    (en_q[i] && sel_in[i] && !sel_q[i]));
    // flag from software, capture or compare match
    assign cc_set[i] = gen_q[BIT_CH0+i] || cap[i] ||
                       (!inmode[i] && match_evt[i]);
    assign cc_clr[i] = (wr && ofs == OFS_STATUS[7:2] &&
                        !hwdata[BIT_CH0+i]) ||
                       (rd_fire && inmode[i] &&
                        ofs == (i == 0 ? OFS_CV0[7:2] : OFS_CV1[7:2]));

    // set wins over clear
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        cc_flag_q[i] <= 1'b0;
      end else if (ce) begin
        if (cc_set[i]) begin
          cc_flag_q[i] <= 1'b1;
        end else if (cc_clr[i]) begin
          cc_flag_q[i] <= 1'b0;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (sys_rst) begin
        ovc_flag_q[i] <= 1'b0;
      end else if (ce) begin
        if (cap[i] && cc_flag_q[i]) begin
          ovc_flag_q[i] <= 1'b1;
        end else if (wr && ofs == OFS_STATUS[7:2] &&
                     !hwdata[BIT_OVC0+i]) begin
          ovc_flag_q[i] <= 1'b0;
        end
      end
    end

    // shadow written, active loaded on update
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        cv_sh_q[i]  <= '0;
        cv_act_q[i] <= '0;
      end else if (ce) begin
        if (cap[i]) begin
          cv_sh_q[i]  <= cnt_val;
          cv_act_q[i] <= cnt_val;
        end else if (wr_cv[i] && !inmode[i]) begin
          cv_sh_q[i] <= hwdata[CW-1:0];
          if (!cfg[i].shadow_en) begin
            cv_act_q[i] <= hwdata[CW-1:0];
          end
        end else if (upd_evt && cfg[i].shadow_en && !inmode[i]) begin
          cv_act_q[i] <= cv_sh_q[i];
        end
      end
    end

    oc_channel #(
      .CW(CW)
    ) u_oc (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .cnt       (cnt_val),
      .cnt_down  (cnt_down),
      .cmp_val   (cv_act_q[i]),
      .cfg       (cfg[i]),
      .etr_filt  (ext_trigger_filtered),
      .trig_edge (trig_edge),
      .chan_en   (en_q[i]),
      .chan_pol  (pol_q[i]),
      .match_evt (match_evt[i]),
      .pre_q     (pre[i]),
      .pin_q     (chan_output_pin[i])
    );
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      upd_flag_q <= 1'b0;
    end else if (ce) begin
      if (upd_evt) begin
        upd_flag_q <= 1'b1;
      end else if (wr && ofs == OFS_STATUS[7:2] && !hwdata[BIT_UPD]) begin
        upd_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      trg_flag_q <= 1'b0;
    end else if (ce) begin
      if (trg_set) begin
        trg_flag_q <= 1'b1;
      end else if (wr && ofs == OFS_STATUS[7:2] && !hwdata[BIT_TRG]) begin
        trg_flag_q <= 1'b0;
      end
    end
  end

  always_comb begin
    pend = '0;
    pend[BIT_UPD] = upd_flag_q;
    pend[BIT_TRG] = trg_flag_q;
    pend[BIT_CH0 +: NCH] = cc_flag_q;
    pend[BIT_DMA + BIT_UPD] = upd_flag_q;
    pend[BIT_DMA + BIT_TRG] = trg_flag_q;
    pend[BIT_DMA + BIT_CH0 +: NCH] = cc_flag_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      int_req <= 1'b0;
      dma_req <= 1'b0;
    end else if (ce) begin
      int_req <= |(pend[BIT_DMA-1:0] & ien_q[BIT_DMA-1:0]);
      dma_req <= |(pend[IEN_W-1:BIT_DMA] & ien_q[IEN_W-1:BIT_DMA]);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_load_stb <= 1'b0;
      cnt_load_val <= '0;
      psc_clear    <= 1'b0;
    end else if (ce) begin
      cnt_load_stb <= gen_q[BIT_UPD];
      psc_clear    <= gen_q[BIT_UPD];
      if (gen_q[BIT_UPD]) begin
        cnt_load_val <= cnt_down ? autoreload : '0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);

  chk_upd_flag_set: assert property (
    upd_evt |=> upd_flag_q)
    else $error("update flag not set");
  chk_trig_flag_set: assert property (
    gen_q[BIT_TRG] |=> trg_flag_q ##1 (trg_flag_q || $past(wr)))
    else $error("trigger flag not set");
  chk_gen_self_clear: assert property (
    gen_q[BIT_TRG] && !wr |=> !gen_q[BIT_TRG])
    else $error("trigger generation bit stuck");
  chk_chan_flag_set: assert property (
    gen_q[BIT_CH0] |=> cc_flag_q[0])
    else $error("channel flag not set");
  chk_capture_value: assert property (
    gen_q[BIT_CH0] && inmode[0] |=> cv_sh_q[0] == $past(cnt_val))
    else $error("capture value wrong");
  chk_upg_reload: assert property (
    gen_q[BIT_UPD] |=> cnt_load_stb && psc_clear &&
      cnt_load_val == ($past(cnt_down) ? $past(autoreload) : '0))
    else $error("update generation reload wrong");
  chk_mode_locked: assert property (
    wr && ofs == OFS_CHCTL[7:2] && en_q[0]
    |=> ctl_q[1:0] == $past(ctl_q[1:0]))
    else $error("mode select changed while enabled");
  chk_shadow_hold: assert property (
    wr_cv[0] && cfg[0].shadow_en && !inmode[0] && !upd_evt
    |=> cv_act_q[0] == $past(cv_act_q[0]))
    else $error("active value written through shadow");
  chk_swevt_read0: assert property (
    rd_fire && ofs == OFS_SWEVT[7:2] |=> hrdata == RST_WORD)
    else $error("event register read not zero");
endmodule

// *** src/timer_evt_pkg.sv ***
// constants and types for timer event generation and compare control
package timer_evt_pkg;
  localparam int CNT_W = 16;
  localparam int NCH = 2;
  localparam int CFG_W = 8;
  localparam int FAST_DLY_CLK = 3;
  localparam int SLOW_DLY_CLK = 5;
  localparam logic [7:0] OFS_INT_EN = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_SWEVT = 8'h14;
  localparam logic [7:0] OFS_CHCTL = 8'h18;
  localparam logic [7:0] OFS_CHEN = 8'h20;
  localparam logic [7:0] OFS_CV0 = 8'h34;
  localparam logic [7:0] OFS_CV1 = 8'h38;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int BIT_UPD = 0;
  localparam int BIT_CH0 = 1;
  localparam int BIT_TRG = 6;
  localparam int BIT_OVC0 = 9;
  localparam int BIT_DMA = 8;
  localparam int IEN_W = 15;
  localparam int GEN_W = 7;
  localparam int CHEN_STRIDE = 4;
  localparam int BIT_POL = 1;
  localparam int HTRANS_ACT = 1;

  typedef enum logic [2:0] {
    OC_FROZEN = 3'b000,
    OC_SET    = 3'b001,
    OC_CLR    = 3'b010,
    OC_TOGGLE = 3'b011,
    OC_LOW    = 3'b100,
    OC_HIGH   = 3'b101,
    OC_PWM0   = 3'b110,
    OC_PWM1   = 3'b111
  } oc_mode_e;

  typedef enum logic [1:0] {
    MS_OUTPUT = 2'b00,
    MS_OWN    = 2'b01,
    MS_NEIGH  = 2'b10,
    MS_ITS    = 2'b11
  } chan_ms_e;

  typedef struct packed {
    logic     clr_en;
    oc_mode_e oc_mode;
    logic     shadow_en;
    logic     fast_en;
    chan_ms_e ms;
  } chan_cfg_s;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [5:0] word;
  } ahb_ap_s;
endpackage

// *** testbench/pin_side_model.sv ***
// far-side model: channel input pins and output pin watcher
`timescale 1ns/1ps
module pin_side_model (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] in_req,
  input  wire logic [1:0] chan_output_pin,
  output logic      [1:0] own_filtered_input,
  output logic      [1:0] neighbor_filtered_input,
  output logic      [7:0] pin_rises
);
  logic [1:0] pin_seen_q;
  // input levels as asked, cycles with any rising pin edge counted
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      own_filtered_input <= 2'h0;
      pin_seen_q         <= 2'h0;
      pin_rises          <= 8'h00;
    end else begin
      own_filtered_input <= in_req;
      pin_seen_q         <= chan_output_pin;
      pin_rises <= pin_rises + 8'(|(chan_output_pin & ~pin_seen_q));
    end
  end
  // neighbour input of each channel is the other channel's input
  assign neighbor_filtered_input = {own_filtered_input[0],
                                    own_filtered_input[1]};
endmodule

// *** testbench/timer_event_gen_and_compare_ctl_bench.sv ***
// self-checking bench for event generation and compare control
`timescale 1ns/1ps
module timer_event_gen_and_compare_ctl_bench;
  import timer_evt_pkg::*;
  localparam int CW = 16;
  logic          clk = 1'b0;
  logic          sys_rst, ce, hsel, hwrite, hreadyout, hresp;
  logic          update_event_in, trig_edge, trig_src_internal;
  logic          ext_trigger_filtered, internal_trigger_sel, cnt_down;
  logic          cnt_load_stb, psc_clear, int_req, dma_req, seen, pe;
  logic [1:0]    htrans, own_in, neigh_in, chan_output_pin, in_req;
  logic [2:0]    hsize;
  logic [7:0]    pin_rises, r0;
  logic [31:0]   haddr, hwdata, hrdata, rd;
  logic [CW-1:0] cnt_val, autoreload, cnt_load_val, load_v, val, val2;
  integer        errors = 0, n_checks = 0, seed = 67, n_load = 0, n0;
  logic [7:0]    ofs [8] = '{8'h0C, 8'h10, 8'h14, 8'h18,
                             8'h20, 8'h34, 8'h38, 8'h3C};
  logic [2:0]    mtab [5] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h3};
  logic          etab [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  always #12.5 clk = ~clk;

  timer_event_gen_and_compare_ctl #(.CW(CW)) timer_event_gen_and_compare_ctl_inst (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .cnt_val(cnt_val), .cnt_down(cnt_down),
    .autoreload(autoreload), .update_event_in(update_event_in),
    .trig_edge(trig_edge), .trig_src_internal(trig_src_internal),
    .ext_trigger_filtered(ext_trigger_filtered),
    .own_filtered_input(own_in), .neighbor_filtered_input(neigh_in),
    .internal_trigger_sel(internal_trigger_sel),
    .cnt_load_stb(cnt_load_stb), .cnt_load_val(cnt_load_val),
    .psc_clear(psc_clear), .chan_output_pin(chan_output_pin),
    .int_req(int_req), .dma_req(dma_req));

  pin_side_model pin_side_model_inst (
    .clk(clk), .sys_rst(sys_rst), .in_req(in_req),
    .chan_output_pin(chan_output_pin), .own_filtered_input(own_in),
    .neighbor_filtered_input(neigh_in), .pin_rises(pin_rises));

  // counter load strobes seen
  always @(posedge clk) begin
    if (cnt_load_stb === 1'b1 && psc_clear === 1'b1) begin
      n_load <= n_load + 1;
      load_v <= cnt_load_val;
    end
  end

  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_rdy(output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        chk("hreadyout", 32'h1, 32'h0);
        final_report();
      end
      @(negedge clk);
    end
    d = hrdata;
    @(posedge clk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    @(posedge clk);
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy(d);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy(d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    bus(1'b1, a, wd, rd);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    chk(nm, e, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [7:0] cfg(input logic cl, input logic [2:0] oc,
                                     input logic sh, input logic [1:0] ms);
    return {cl, oc, sh, 1'b0, ms};
  endfunction

  function automatic logic pwm_exp(input logic [2:0] m,
                                   input logic [CW-1:0] c,
                                   input logic [CW-1:0] r, input logic dn);
    logic act;
    act = dn ? (c <= r) : (c < r);
    return (m == 3'h6) ? act : ~act;
  endfunction

  initial begin
    {ce, hsel, sys_rst} = 3'b111;
    {hwrite, update_event_in, trig_edge, trig_src_internal} = 4'h0;
    {ext_trigger_filtered, internal_trigger_sel, cnt_down} = 3'h0;
    {haddr, hwdata, htrans, in_req} = '0;
    // word size only on every transfer
    hsize = 3'h2;
    cnt_val = 16'h0000;
    autoreload = 16'hFFFF;
    cyc(16);
    sys_rst <= 1'b0;
    foreach (ofs[i]) rdc("reset word", ofs[i], 32'h0);
    $display("test reset done");
    wr(8'h0C, 32'h4040);
    wr(8'h14, 32'h0);
    cyc(4);
    rdc("status zero write", 8'h10, 32'h0);
    wr(8'h14, 32'h40);
    cyc(4);
    rdc("trigger flag", 8'h10, 32'h40);
    chk("int_req", 32'h1, {31'h0, int_req});
    chk("dma_req", 32'h1, {31'h0, dma_req});
    rdc("event reg", 8'h14, 32'h0);
    wr(8'h10, 32'h0);
    @(posedge clk) update_event_in <= 1'b1;
    @(posedge clk) update_event_in <= 1'b0;
    cyc(6);
    chk("int_req off", 32'h0, {31'h0, int_req});
    chk("dma_req off", 32'h0, {31'h0, dma_req});
    rdc("update flag", 8'h10, 32'h1);
    wr(8'h10, 32'h0);
    $display("test flags done");
    for (int k = 0; k < 2; k++) begin
      n0 = n_load;
      cnt_down <= k[0];
      autoreload <= 16'($random(seed));
      wr(8'h14, 32'h1);
      cyc(4);
      chk("load count", n0 + 1, n_load);
      chk("load value", k ? autoreload : 0, load_v);
    end
    cnt_down <= 1'b0;
    wr(8'h10, 32'h0);
    $display("test update gen done");
    wr(8'h18, cfg(0, 3'h0, 0, 2'h1));
    cnt_val <= 16'($random(seed));
    wr(8'h14, 32'h2);
    wr(8'h14, 32'h4);
    cyc(4);
    rdc("chan flags", 8'h10, 32'h6);
    cnt_val <= 16'($random(seed));
    wr(8'h14, 32'h2);
    cyc(4);
    rdc("overcapture", 8'h10, 32'h206);
    rdc("capture value", 8'h34, {16'h0, cnt_val});
    wr(8'h20, 32'h1);
    wr(8'h18, 32'h0);
    rdc("locked mode", 8'h18, 32'h1);
    cnt_val <= 16'($random(seed));
    in_req <= 2'h1;
    cyc(6);
    rdc("pin capture", 8'h34, {16'h0, cnt_val});
    wr(8'h18, 32'h0301);
    wr(8'h20, 32'h11);
    {trig_src_internal, internal_trigger_sel} <= 2'h3;
    cnt_val <= 16'($random(seed));
    cyc(4);
    rdc("trigger capture", 8'h38, {16'h0, cnt_val});
    {in_req, cnt_val} <= '0;
    {trig_src_internal, internal_trigger_sel} <= 2'h0;
    wr(8'h20, 32'h0);
    wr(8'h18, 32'h0);
    wr(8'h10, 32'h0);
    $display("test capture done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, {26'h0, i[0], 1'b1, 4'h0});
      wr(8'h18, {16'h0, cfg(0, {2'h2, i[1]}, 0, 2'h0), 8'h0});
      cyc(4);
      chk("forced pin", i[1] ^ i[0], chan_output_pin[1]);
      chk("pin0 off", 32'h0, {31'h0, chan_output_pin[0]});
    end
    wr(8'h18, {16'h0, cfg(1, 3'h5, 0, 2'h0), 8'h0});
    ext_trigger_filtered <= 1'b1;
    cyc(4);
    chk("clear enable", 32'h1, {31'h0, chan_output_pin[1]});
    ext_trigger_filtered <= 1'b0;
    wr(8'h18, {16'h0, cfg(0, 3'h4, 0, 2'h0), 8'h0});
    wr(8'h20, 32'h10);
    val = (16'($random(seed)) & 16'h7FFF) + 16'h0010;
    wr(8'h38, {16'h0, val});
    r0 = pin_rises;
    foreach (mtab[i]) begin
      wr(8'h18, {16'h0, cfg(0, mtab[i], 0, 2'h0), 8'h0});
      cnt_val <= val + 16'h0001;
      cyc(3);
      cnt_val <= val;
      cyc(4);
      chk("match pin", etab[i], chan_output_pin[1]);
    end
    chk("pin rises", r0 + 8'h2, pin_rises);
    $display("test compare done");
    for (int k = 0; k < 4; k++) begin
      cnt_down <= k[0];
      // shadow kept on in pwm
      wr(8'h18, {16'h0, cfg(0, {2'h3, k[1]}, 1, 2'h0), 8'h0});
      repeat (8) begin
        cnt_val <= val - 16'h0003 + 16'($random(seed) & 7);
        cyc(4);
        pe = pwm_exp({2'h3, k[1]}, cnt_val, val, k[0]);
        chk("pwm pin", pe, chan_output_pin[1]);
      end
    end
    cnt_down <= 1'b0;
    wr(8'h18, {16'h0, cfg(0, 3'h6, 1, 2'h0), 8'h0});
    cnt_val <= val - 16'h0001;
    val2 = val - 16'h0008;
    wr(8'h38, {16'h0, val2});
    cyc(4);
    chk("shadow hold", 32'h1, {31'h0, chan_output_pin[1]});
    @(posedge clk) update_event_in <= 1'b1;
    @(posedge clk) update_event_in <= 1'b0;
    cyc(4);
    chk("shadow load", 32'h0, {31'h0, chan_output_pin[1]});
    $display("test pwm done");
    cnt_val <= val2 - 16'h0004;
    wr(8'h18, {16'h0, cfg(0, 3'h7, 1, 2'h0) | 8'h04, 8'h0});
    cyc(4);
    chk("fast before", 32'h0, {31'h0, chan_output_pin[1]});
    @(posedge clk) trig_edge <= 1'b1;
    @(posedge clk) trig_edge <= 1'b0;
    seen = 1'b0;
    repeat (2) begin
      @(negedge clk) seen = seen | chan_output_pin[1];
      @(posedge clk);
    end
    chk("fast trigger", 32'h1, {31'h0, seen});
    $display("test fast done");
    final_report();
  end
endmodule
